// >>> core/kdc_pkg.sv
package kdc_pkg;
  localparam int          KDC_SLOTS      = 16;
  // command opcodes
  localparam logic [7:0]  OP_COUNTER     = 8'h24;
  localparam logic [7:0]  OP_DERIVE      = 8'h1C;
  localparam logic [7:0]  OP_ECDH        = 8'h43;
  // one-byte results
  localparam logic [7:0]  RES_OK         = 8'h00;
  localparam logic [7:0]  ERR_MAC        = 8'h01;
  localparam logic [7:0]  ERR_PARSE      = 8'h03;
  localparam logic [7:0]  ERR_EXEC       = 8'h0F;
  // mode bits
  localparam logic [7:0]  MODE_RANDOM    = 8'h04;
  localparam int          MODE_INC       = 0;
  // slot_settings fields
  localparam int          SS_RK_ECDH     = 2;
  localparam int          SS_RK_PAIR     = 3;
  localparam int          SS_LIMITED     = 5;
  localparam int          SS_PARENT      = 8;
  localparam int          SS_FROM_PARENT = 12;
  localparam int          SS_DERIVE_OK   = 13;
  localparam int          SS_NEED_MAC    = 15;
  // key_settings fields
  localparam int          KS_PRIVATE     = 0;
  localparam int          KS_NEED_RANDOM = 6;
  localparam int          KS_NEED_AUTH   = 7;
  localparam int          KS_AUTH_IDX    = 8;
  // counters
  localparam int          CNT_W          = 22;
  localparam logic [21:0] CNT_MAX        = 22'h1FFFFF;
  // byte counts
  localparam logic [6:0]  LEN_MAC        = 7'h20;
  localparam logic [6:0]  LEN_ECDH       = 7'h40;
  localparam logic [6:0]  MSG_MAC_LEN    = 7'h27;
  localparam logic [6:0]  MSG_DER_LEN    = 7'h60;
  localparam logic [6:0]  MSG_TK_START   = 7'h40;
  localparam logic [5:0]  RSP_COUNT_LEN  = 6'h04;
  localparam logic [5:0]  RSP_KEY_LEN    = 6'h20;
endpackage

// >>> core/kdc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface kdc_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_opcode;
  logic [7:0]  cmd_param1;
  logic [15:0] cmd_param2;
  logic        dat_valid;
  logic        dat_ready;
  logic [7:0]  dat_byte;
  logic        rsp_valid;
  logic        rsp_last;
  logic [7:0]  rsp_byte;
  modport dev (input cmd_valid, cmd_opcode, cmd_param1, cmd_param2, dat_valid, dat_byte,
               output cmd_ready, dat_ready, rsp_valid, rsp_last, rsp_byte);
  modport host (output cmd_valid, cmd_opcode, cmd_param1, cmd_param2, dat_valid, dat_byte,
                input cmd_ready, dat_ready, rsp_valid, rsp_last, rsp_byte);
endinterface
`default_nettype wire

// >>> core/kdc_device.sv
`timescale 1ns/1ps
`default_nettype none
module kdc_device
  import kdc_pkg::*;
#(
  parameter int SLOTS = KDC_SLOTS
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // host link
  kdc_if.dev                 link,
  // slot configuration
  input  wire logic [15:0]   slot_settings [KDC_SLOTS],
  input  wire logic [15:0]   key_settings [KDC_SLOTS],
  input  wire logic [15:0]   per_slot_lock,
  input  wire logic          config_locked,
  // scratch key register, authorization state and serial number
  input  wire logic          tk_valid,
  input  wire logic          tk_random,
  input  wire logic [255:0]  tk_value,
  input  wire logic          auth_valid,
  input  wire logic [3:0]    auth_idx,
  input  wire logic [71:0]   serial_number_bytes,
  // monotonic counters
  input  wire logic [21:0]   cnt_value [2],
  output logic               cnt_inc,
  output logic               cnt_sel,
  // key storage
  output logic [3:0]         key_rd_idx,
  input  wire logic [255:0]  key_rd_data,
  output logic               slot_wr_en,
  output logic [3:0]         slot_wr_idx,
  output logic [255:0]       slot_wr_data,
  // hash engine
  output logic               sha_start,
  output logic               sha_valid,
  output logic               sha_last,
  output logic [7:0]         sha_byte,
  input  wire logic          sha_done,
  input  wire logic [255:0]  sha_digest,
  // curve engine
  output logic               ecc_start,
  output logic [3:0]         ecc_idx,
  output logic [255:0]       ecc_x,
  output logic [255:0]       ecc_y,
  input  wire logic          ecc_done,
  input  wire logic          ecc_ok,
  input  wire logic [255:0]  ecc_secret
);
  if (SLOTS != KDC_SLOTS) begin : g_chk
    $error("kdc_device serves exactly 16 slots");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, ST_RX   = 4'h1, ST_CHK  = 4'h3, ST_LOAD = 4'h2,
    ST_MAC   = 4'h6, ST_MWAIT = 4'h7, ST_DER = 4'h5, ST_DWAIT = 4'h4,
    ST_ECC   = 4'hC, ST_RSP  = 4'h8
  } kdc_dstate_t;

  kdc_dstate_t  state_reg;
  logic [7:0]   op_reg;
  logic [7:0]   p1_reg;
  logic [15:0]  p2_reg;
  logic [6:0]   len_reg;
  logic [6:0]   cnt_reg;
  logic [511:0] rx_reg;
  logic [255:0] key_reg;
  logic [255:0] rsp_reg;
  logic [5:0]   rlen_reg;
  logic         der_reg;
  logic [7:0]   err_next;
  logic [7:0]   msg_byte;
  logic [6:0]   len_in;
  logic [31:0]  count_next;

  wire logic [3:0]  tgt  = p2_reg[3:0];
  wire logic [15:0] ss   = slot_settings[tgt];
  wire logic [15:0] ks   = key_settings[tgt];
  wire logic [3:0]  par  = ss[SS_PARENT +: 4];
  wire logic [15:0] pss  = slot_settings[par];
  wire logic [15:0] pks  = key_settings[par];
  wire logic        roll = !ss[SS_FROM_PARENT];
  wire logic [3:0]  src  = roll ? tgt : par;

  assign ecc_x = rx_reg[511:256];
  assign ecc_y = rx_reg[255:0];

  // prior authorization seen for the key's authorizing slot
  function automatic logic auth_ok(input logic [15:0] k, input logic av, input logic [3:0] ai);
    auth_ok = av && (ai == k[KS_AUTH_IDX +: 4]);
  endfunction

  always_comb begin
    len_in = 7'h00;
    if (link.cmd_opcode == OP_ECDH) begin
      len_in = LEN_ECDH;
    end else if (link.cmd_opcode == OP_DERIVE && slot_settings[link.cmd_param2[3:0]][SS_NEED_MAC]) begin
      len_in = LEN_MAC;
    end
  end

  always_comb begin
    err_next = RES_OK;
    case (op_reg)
      OP_COUNTER: begin
        if (p1_reg[7:1] != 7'h00 || p2_reg > 16'h0001) begin
          err_next = ERR_PARSE;
        end else if (p1_reg[MODE_INC] && cnt_value[p2_reg[0]] == CNT_MAX) begin
          err_next = ERR_EXEC;
        end
      end
      OP_DERIVE: begin
        if ((p1_reg & ~MODE_RANDOM) != 8'h00) begin
          err_next = ERR_PARSE;
        end else if (!ss[SS_DERIVE_OK]
                     || ks[KS_PRIVATE] || !config_locked || per_slot_lock[tgt]
                     || !tk_valid || (key_settings[src][KS_NEED_RANDOM] && !tk_random)
                     || (p1_reg[2] != tk_random)
                     || (roll && ks[KS_NEED_AUTH] && !auth_ok(ks, auth_valid, auth_idx))
                     || ((!roll || ss[SS_NEED_MAC]) && pks[KS_NEED_AUTH]
                         && !auth_ok(pks, auth_valid, auth_idx))
                     || ((!roll || ss[SS_NEED_MAC]) && pss[SS_LIMITED] && cnt_value[0] == CNT_MAX)) begin
          err_next = ERR_EXEC;
        end
      end
      OP_ECDH: begin
        if (p1_reg != 8'h00 || (ss[SS_RK_PAIR] && p2_reg[0])) begin
          err_next = ERR_PARSE;
        end else if (!ss[SS_RK_ECDH]) begin
          err_next = ERR_EXEC;
        end
      end
      default: err_next = ERR_PARSE;
    endcase
  end

  // hash message bytes, key first; only the derive message goes on to end with the scratch value
  always_comb begin
    msg_byte = 8'h00;
    if (cnt_reg < LEN_MAC) begin
      msg_byte = key_reg[{~cnt_reg[4:0], 3'b000} +: 8];
    end else if (cnt_reg >= MSG_TK_START) begin
      msg_byte = tk_value[{~cnt_reg[4:0], 3'b000} +: 8];
    end else begin
      case (cnt_reg)
        7'h20:   msg_byte = op_reg;
        7'h21:   msg_byte = p1_reg;
        7'h22:   msg_byte = p2_reg[7:0];
        7'h23:   msg_byte = p2_reg[15:8];
        7'h24:   msg_byte = serial_number_bytes[71:64];
        7'h25:   msg_byte = serial_number_bytes[7:0];
        7'h26:   msg_byte = serial_number_bytes[15:8];
        default: msg_byte = 8'h00;
      endcase
    end
  end

  assign count_next = {10'h000, cnt_value[p2_reg[0]] + {21'h000000, p1_reg[MODE_INC]}};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_reg <= '0;
    end else if (state_reg == ST_RX && link.dat_valid) begin
      rx_reg <= {rx_reg[503:0], link.dat_byte};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= ST_IDLE;
      op_reg         <= 8'h00;
      p1_reg         <= 8'h00;
      p2_reg         <= 16'h0000;
      len_reg        <= 7'h00;
      cnt_reg        <= 7'h00;
      key_reg        <= '0;
      rsp_reg        <= '0;
      rlen_reg       <= 6'h00;
      der_reg        <= 1'b0;
      link.cmd_ready <= 1'b0;
      link.dat_ready <= 1'b0;
      link.rsp_valid <= 1'b0;
      link.rsp_last  <= 1'b0;
      link.rsp_byte  <= 8'h00;
      cnt_inc        <= 1'b0;
      cnt_sel        <= 1'b0;
      key_rd_idx     <= 4'h0;
      slot_wr_en     <= 1'b0;
      slot_wr_idx    <= 4'h0;
      slot_wr_data   <= '0;
      sha_start      <= 1'b0;
      sha_valid      <= 1'b0;
      sha_last       <= 1'b0;
      sha_byte       <= 8'h00;
      ecc_start      <= 1'b0;
      ecc_idx        <= 4'h0;
    end else begin
      sha_start      <= 1'b0;
      sha_valid      <= 1'b0;
      sha_last       <= 1'b0;
      ecc_start      <= 1'b0;
      slot_wr_en     <= 1'b0;
      cnt_inc        <= 1'b0;
      link.rsp_valid <= 1'b0;
      link.rsp_last  <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          link.cmd_ready <= 1'b1;
          if (link.cmd_valid && link.cmd_ready) begin
            link.cmd_ready <= 1'b0;
            op_reg         <= link.cmd_opcode;
            p1_reg         <= link.cmd_param1;
            p2_reg         <= link.cmd_param2;
            len_reg        <= len_in;
            cnt_reg        <= 7'h00;
            der_reg        <= 1'b0;
            link.dat_ready <= (len_in != 7'h00);
            state_reg      <= (len_in != 7'h00) ? ST_RX : ST_CHK;
          end
        end
        ST_RX: begin
          if (link.dat_valid) begin
            cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg == len_reg - 7'h01) begin
              link.dat_ready <= 1'b0;
              cnt_reg        <= 7'h00;
              state_reg      <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          if (err_next != RES_OK) begin
            rsp_reg   <= {err_next, 248'h0};
            rlen_reg  <= 6'h01;
            state_reg <= ST_RSP;
          end else if (op_reg == OP_COUNTER) begin
            cnt_inc   <= p1_reg[MODE_INC];
            cnt_sel   <= p2_reg[0];
            rsp_reg   <= {count_next[7:0], count_next[15:8], count_next[23:16], count_next[31:24], 224'h0};
            rlen_reg  <= RSP_COUNT_LEN;
            state_reg <= ST_RSP;
          end else if (op_reg == OP_DERIVE) begin
            // the MAC always uses the parent key, whatever bit 12 says
            key_rd_idx <= ss[SS_NEED_MAC] ? par : src;
            der_reg    <= !ss[SS_NEED_MAC];
            state_reg  <= ST_LOAD;
          end else begin
            ecc_start <= 1'b1;
            ecc_idx   <= tgt;
            state_reg <= ST_ECC;
          end
        end
        ST_LOAD: begin
          key_reg   <= key_rd_data;
          sha_start <= 1'b1;
          cnt_reg   <= 7'h00;
          state_reg <= der_reg ? ST_DER : ST_MAC;
        end
        ST_MAC, ST_DER: begin
          sha_valid <= 1'b1;
          sha_byte  <= msg_byte;
          cnt_reg   <= cnt_reg + 7'h01;
          if (cnt_reg == ((state_reg == ST_MAC) ? MSG_MAC_LEN : MSG_DER_LEN) - 7'h01) begin
            sha_last  <= 1'b1;
            state_reg <= (state_reg == ST_MAC) ? ST_MWAIT : ST_DWAIT;
          end
        end
        ST_MWAIT: begin
          if (sha_done) begin
            if (sha_digest != rx_reg[255:0]) begin
              rsp_reg   <= {ERR_MAC, 248'h0};
              rlen_reg  <= 6'h01;
              state_reg <= ST_RSP;
            end else begin
              key_rd_idx <= src;
              der_reg    <= 1'b1;
              state_reg  <= ST_LOAD;
            end
          end
        end
        ST_DWAIT: begin
          if (sha_done) begin
            slot_wr_en   <= 1'b1;
            slot_wr_idx  <= tgt;
            slot_wr_data <= sha_digest;
            rsp_reg      <= {RES_OK, 248'h0};
            rlen_reg     <= 6'h01;
            state_reg    <= ST_RSP;
          end
        end
        ST_ECC: begin
          if (ecc_done) begin
            state_reg <= ST_RSP;
            rsp_reg   <= {ecc_ok ? RES_OK : ERR_EXEC, 248'h0};
            rlen_reg  <= 6'h01;
            if (ecc_ok && ss[SS_RK_PAIR]) begin
              slot_wr_en   <= 1'b1;
              slot_wr_idx  <= tgt + 4'h1;
              slot_wr_data <= ecc_secret;
            end else if (ecc_ok) begin
              rsp_reg  <= ecc_secret;
              rlen_reg <= RSP_KEY_LEN;
            end
          end
        end
        ST_RSP: begin
          link.rsp_valid <= 1'b1;
          link.rsp_byte  <= rsp_reg[255:248];
          rsp_reg        <= {rsp_reg[247:0], 8'h00};
          rlen_reg       <= rlen_reg - 6'h01;
          if (rlen_reg == 6'h01) begin
            link.rsp_last <= 1'b1;
            state_reg     <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> core/kdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module kdc_host
  import kdc_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // device link
  kdc_if.host                link,
  // request
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic [7:0]    req_opcode,
  input  wire logic [7:0]    req_param1,
  input  wire logic [15:0]   req_param2,
  input  wire logic [511:0]  req_data,
  input  wire logic [6:0]    req_len,
  input  wire logic          tk_loaded,
  input  wire logic          ecdh_pair,
  // answer
  output logic               rsp_done,
  output logic               rsp_refused,
  output logic [5:0]         rsp_len,
  output logic [255:0]       rsp_data
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_CMD = 2'b01, H_DATA = 2'b11, H_WAIT = 2'b10
  } kdc_hstate_t;

  kdc_hstate_t  state_reg;
  logic [511:0] data_reg;
  logic [6:0]   len_reg;
  logic [6:0]   cnt_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= H_IDLE;
      data_reg        <= '0;
      len_reg         <= 7'h00;
      cnt_reg         <= 7'h00;
      req_ready       <= 1'b0;
      rsp_done        <= 1'b0;
      rsp_refused     <= 1'b0;
      rsp_len         <= 6'h00;
      rsp_data        <= '0;
      link.cmd_valid  <= 1'b0;
      link.cmd_opcode <= 8'h00;
      link.cmd_param1 <= 8'h00;
      link.cmd_param2 <= 16'h0000;
      link.dat_valid  <= 1'b0;
      link.dat_byte   <= 8'h00;
    end else begin
      rsp_done    <= 1'b0;
      rsp_refused <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            if (req_opcode == OP_DERIVE && !tk_loaded) begin
              // no nonce yet: the device would only refuse it
              rsp_done    <= 1'b1;
              rsp_refused <= 1'b1;
              rsp_len     <= 6'h00;
            end else begin
              link.cmd_valid  <= 1'b1;
              link.cmd_opcode <= req_opcode;
              link.cmd_param1 <= req_param1;
              link.cmd_param2 <= req_param2;
              len_reg         <= req_len;
              if (req_opcode == OP_DERIVE) begin
                link.cmd_param1 <= req_param1 & MODE_RANDOM;
              end
              if (req_opcode == OP_ECDH) begin
                link.cmd_param1 <= 8'h00;
                len_reg         <= LEN_ECDH;
                link.cmd_param2 <= {req_param2[15:1], req_param2[0] & !ecdh_pair};
              end
              data_reg  <= req_data;
              rsp_data  <= '0;
              rsp_len   <= 6'h00;
              cnt_reg   <= 7'h00;
              state_reg <= H_CMD;
            end
          end
        end
        H_CMD: begin
          if (link.cmd_ready) begin
            link.cmd_valid <= 1'b0;
            if (len_reg == 7'h00) begin
              state_reg <= H_WAIT;
            end else begin
              link.dat_valid <= 1'b1;
              link.dat_byte  <= data_reg[511:504];
              data_reg       <= {data_reg[503:0], 8'h00};
              state_reg      <= H_DATA;
            end
          end
        end
        H_DATA: begin
          if (link.dat_ready) begin
            cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg == len_reg - 7'h01) begin
              link.dat_valid <= 1'b0;
              state_reg      <= H_WAIT;
            end else begin
              link.dat_byte <= data_reg[511:504];
              data_reg      <= {data_reg[503:0], 8'h00};
            end
          end
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            rsp_data <= {rsp_data[247:0], link.rsp_byte};
            rsp_len  <= rsp_len + 6'h01;
            if (link.rsp_last) begin
              rsp_done  <= 1'b1;
              state_reg <= H_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/kdc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module kdc_sva
  import kdc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // link
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_opcode,
  input wire logic [7:0]  cmd_param1,
  input wire logic [15:0] cmd_param2,
  input wire logic        dat_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_last,
  input wire logic [7:0]  rsp_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic       take;
  logic [7:0] op_reg;
  assign take = cmd_valid && cmd_ready;
  // opcode of the command now in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) op_reg <= 8'h00;
    else if (take) op_reg <= cmd_opcode;
  end
  sequence s_four_bytes;
    (rsp_valid && !rsp_last) [*3] ##1 (rsp_valid && rsp_last);
  endsequence
  sequence s_parse_err;
    rsp_valid && rsp_last && rsp_byte == ERR_PARSE;
  endsequence
  a_last_has_byte: assert property (rsp_last |-> rsp_valid)
    else $error("last flag without byte");
  a_ready_after_last: assert property (rsp_last |=> cmd_ready)
    else $error("ready not back after reply");
  a_counter_four: assert property (take && cmd_opcode == OP_COUNTER && cmd_param2 < 16'h0002
    && cmd_param1 == 8'h00 |-> ##3 s_four_bytes) else $error("counter reply not four bytes");
  // an increment may fail at the limit; then a lone byte must be the exec code
  a_counter_inc: assert property (take && cmd_opcode == OP_COUNTER && cmd_param2 < 16'h0002
    && cmd_param1 == 8'h01 |-> ##3 (rsp_valid && (!rsp_last || rsp_byte == ERR_EXEC)))
    else $error("counter increment reply malformed");
  a_counter_bad_idx: assert property (take && cmd_opcode == OP_COUNTER && cmd_param2 > 16'h0001
    |-> ##3 s_parse_err) else $error("bad counter index not refused");
  a_derive_mode_zero: assert property (cmd_valid && cmd_opcode == OP_DERIVE
    |-> (cmd_param1 & 8'hFB) == 8'h00) else $error("derive mode bits not zero");
  a_ecdh_mode_zero: assert property (cmd_valid && cmd_opcode == OP_ECDH |-> cmd_param1 == 8'h00)
    else $error("ecdh mode not zero");
  a_derive_one_byte: assert property (rsp_valid && op_reg == OP_DERIVE |-> rsp_last)
    else $error("derive reply longer than one byte");
  a_ecdh_collects: assert property (take && cmd_opcode == OP_ECDH |-> ##[1:2] dat_ready)
    else $error("ecdh point not collected");
endmodule
`default_nettype wire

// >>> tb/test_key_derivation_and_ecdh_checker.sv
`timescale 1ns/1ps
`default_nettype none
module test_key_derivation_and_ecdh_checker
  import kdc_pkg::*;
;
  localparam logic [255:0] DIG = {32{8'hA5}};
  localparam logic [255:0] SEC = {16{16'hC35A}};
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic [15:0]  ss [KDC_SLOTS];
  logic [15:0]  ks [KDC_SLOTS];
  logic [255:0] keys [KDC_SLOTS];
  logic [21:0]  cnt [2];
  logic [15:0]  lock_mask;
  logic         cfg_lock, tk_rnd, tk_loaded, auth_v, req_valid, ecdh_pair;
  logic [7:0]   op, p1;
  logic [15:0]  p2;
  logic [6:0]   len;
  logic [511:0] rdata;
  logic [2:0]   sha_sr = 3'h0;
  logic [2:0]   ecc_sr = 3'h0;
  logic [7:0]   msg [$];
  int           wr_n = 0;
  int           mismatches = 0;
  int           tests_run = 0;
  logic         cnt_inc, cnt_sel, slot_wr_en, sha_start, sha_valid, sha_last, ecc_start;
  logic [3:0]   key_rd_idx, slot_wr_idx, ecc_idx;
  logic [255:0] key_rd_data, slot_wr_data, ecc_x, ecc_y, rsp_data;
  logic [7:0]   sha_byte;
  logic         req_ready, rsp_done, rsp_refused;
  logic [5:0]   rsp_len;
  kdc_if kdc_if_inst ();
  kdc_device kdc_device_inst (.clk(clk), .nrst(nrst), .link(kdc_if_inst.dev), .slot_settings(ss),
    .key_settings(ks), .per_slot_lock(lock_mask), .config_locked(cfg_lock), .tk_valid(tk_loaded),
    .tk_random(tk_rnd), .tk_value({32{8'h77}}), .auth_valid(auth_v), .auth_idx(4'h0),
    .serial_number_bytes(72'h99_8877_6655_4433_2211), .cnt_value(cnt), .cnt_inc(cnt_inc), .cnt_sel(cnt_sel),
    .key_rd_idx(key_rd_idx), .key_rd_data(key_rd_data), .slot_wr_en(slot_wr_en), .slot_wr_idx(slot_wr_idx),
    .slot_wr_data(slot_wr_data), .sha_start(sha_start), .sha_valid(sha_valid), .sha_last(sha_last),
    .sha_byte(sha_byte), .sha_done(sha_sr[2]), .sha_digest(DIG), .ecc_start(ecc_start), .ecc_idx(ecc_idx),
    .ecc_x(ecc_x), .ecc_y(ecc_y), .ecc_done(ecc_sr[2]), .ecc_ok(1'b1), .ecc_secret(SEC));
  kdc_host kdc_host_inst (.clk(clk), .nrst(nrst), .link(kdc_if_inst.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_opcode(op), .req_param1(p1), .req_param2(p2), .req_data(rdata),
    .req_len(len), .tk_loaded(tk_loaded), .ecdh_pair(ecdh_pair), .rsp_done(rsp_done),
    .rsp_refused(rsp_refused), .rsp_len(rsp_len), .rsp_data(rsp_data));
  kdc_sva kdc_sva_inst (.clk(clk), .nrst(nrst), .cmd_valid(kdc_if_inst.cmd_valid),
    .cmd_ready(kdc_if_inst.cmd_ready), .cmd_opcode(kdc_if_inst.cmd_opcode),
    .cmd_param1(kdc_if_inst.cmd_param1), .cmd_param2(kdc_if_inst.cmd_param2),
    .dat_ready(kdc_if_inst.dat_ready), .rsp_valid(kdc_if_inst.rsp_valid),
    .rsp_last(kdc_if_inst.rsp_last), .rsp_byte(kdc_if_inst.rsp_byte));
  always #20 clk = ~clk;
  assign key_rd_data = keys[key_rd_idx];
  // engines answer a fixed three cycles late
  always @(posedge clk) begin
    sha_sr <= {sha_sr[1:0], sha_last};
    ecc_sr <= {ecc_sr[1:0], ecc_start};
    if (sha_start) msg.delete();
    if (sha_valid) msg.push_back(sha_byte);
    if (slot_wr_en) keys[slot_wr_idx] <= slot_wr_data;
    if (slot_wr_en) wr_n++;
    if (cnt_inc) cnt[cnt_sel] <= cnt[cnt_sel] + 22'h1;
  end
  task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic [7:0] o, input logic [7:0] a, input logic [15:0] b, input logic [6:0] n);
    int t;
    op <= o; p1 <= a; p2 <= b; len <= n; req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    t = 0;
    do begin @(posedge clk); t++; end while (rsp_done !== 1'b1 && t < 600);
    if (rsp_done !== 1'b1) mismatches++;
  endtask
  // counter bytes arrive lsb first, last one lands in bits 7:0
  function automatic logic [31:0] cbytes(input logic [21:0] v);
    return {v[7:0], v[15:8], 2'b00, v[21:16], 8'h00};
  endfunction
  task automatic t_counter();
    cnt[0] <= 22'h012345; cnt[1] <= CNT_MAX;
    run(OP_COUNTER, 8'h00, 16'h0000, 7'h00);
    check("cnt_read", {rsp_len, rsp_data[31:0]}, {6'h04, cbytes(22'h012345)});
    run(OP_COUNTER, 8'h01, 16'h0000, 7'h00);
    check("cnt_inc", {rsp_len, rsp_data[31:0]}, {6'h04, cbytes(22'h012346)});
    check("cnt_stored", cnt[0], 22'h012346);
    run(OP_COUNTER, 8'h00, 16'h0002, 7'h00);
    check("cnt_badidx", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_PARSE});
    run(OP_COUNTER, 8'h01, 16'h0001, 7'h00);
    check("cnt_atmax", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_EXEC});
    check("cnt_kept", cnt[1], CNT_MAX);
    run(8'h15, 8'h00, 16'h0000, 7'h00);
    check("op_unknown", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_PARSE});
  endtask
  task automatic bad(input logic [15:0] s1, k1, s9, k9, input logic c, l, r, m);
    int w;
    ss[1] <= s1; ks[1] <= k1; ss[9] <= s9; ks[9] <= k9; cfg_lock <= c; tk_rnd <= r;
    lock_mask <= {14'h0, l, 1'b0}; cnt[0] <= m ? CNT_MAX : 22'h0;
    w = wr_n;
    run(OP_DERIVE, 8'h00, 16'h0001, 7'h00);
    check("der_err", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_EXEC});
    check("der_nowrite", wr_n, w);
  endtask
  task automatic t_refused();
    bad(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    bad(16'h2000, 16'h0001, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    bad(16'h2000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
    bad(16'h2000, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 1'b0, 1'b0);
    bad(16'h2000, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b0);
    bad(16'h2000, 16'h0040, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    bad(16'h2000, 16'h0080, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    bad(16'h3900, 16'h0000, 16'h0000, 16'h0080, 1'b1, 1'b0, 1'b0, 1'b0);
    bad(16'h3900, 16'h0000, 16'h0020, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b1);
    tk_loaded <= 1'b0;
    run(OP_DERIVE, 8'h00, 16'h0001, 7'h00);
    check("host_refuse", {rsp_refused, rsp_len}, {1'b1, 6'h00});
    tk_loaded <= 1'b1;
  endtask
  task automatic t_derive_ok();
    ss[2] <= 16'h2020; ss[3] <= 16'h3600; cfg_lock <= 1'b1; lock_mask <= 16'h0000;
    tk_rnd <= 1'b1; cnt[0] <= CNT_MAX;
    run(OP_DERIVE, MODE_RANDOM, 16'h0002, 7'h00);
    check("roll_rsp", {rsp_len, rsp_data[7:0]}, {6'h01, RES_OK});
    check("roll_key", keys[2], DIG);
    check("roll_src", msg[0], 8'h12);
    check("msg_len", msg.size(), 96);
    check("msg_hdr", {msg[32], msg[33], msg[34], msg[35], msg[36], msg[37], msg[38]},
          {OP_DERIVE, MODE_RANDOM, 16'h0200, 24'h991122});
    for (int i = 39; i < 96; i++) check("msg_tail", msg[i], (i < 64) ? 8'h00 : 8'h77);
    run(OP_DERIVE, MODE_RANDOM, 16'h0003, 7'h00);
    check("create_src", msg[0], 8'h16);
    check("create_key", keys[3], DIG);
    ss[3] <= 16'hB600; rdata <= 512'h0;
    run(OP_DERIVE, MODE_RANDOM, 16'h0003, 7'h20);
    check("mac_bad", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_MAC});
    rdata <= {DIG, 256'h0};
    run(OP_DERIVE, MODE_RANDOM, 16'h0003, 7'h20);
    check("mac_good", {rsp_len, rsp_data[7:0]}, {6'h01, RES_OK});
  endtask
  task automatic t_ecdh();
    ss[4] <= 16'h0000; ecdh_pair <= 1'b0; rdata <= {{8{32'h13579BDF}}, {8{32'h2468ACE0}}};
    run(OP_ECDH, 8'h00, 16'h0004, 7'h40);
    check("ecdh_off", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_EXEC});
    ss[4] <= 16'h0004;
    run(OP_ECDH, 8'h00, 16'h0004, 7'h40);
    check("ecdh_clear", rsp_data, SEC);
    check("ecdh_len", rsp_len, 6'h20);
    check("ecdh_x", ecc_x, rdata[511:256]);
    check("ecdh_y", ecc_y, rdata[255:0]);
    check("ecdh_idx", ecc_idx, 4'h4);
    ss[4] <= 16'h000C; ecdh_pair <= 1'b1;
    run(OP_ECDH, 8'h00, 16'h0004, 7'h40);
    check("ecdh_stored", {rsp_len, rsp_data[7:0]}, {6'h01, RES_OK});
    check("ecdh_slot", keys[5], SEC);
    ss[5] <= 16'h000C;
    ecdh_pair <= 1'b0;
    run(OP_ECDH, 8'h00, 16'h0005, 7'h40);
    check("ecdh_odd", {rsp_len, rsp_data[7:0]}, {6'h01, ERR_PARSE});
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < KDC_SLOTS; i++) begin
      ss[i] = 16'h0000;
      ks[i] = 16'h0000;
      keys[i] = {32{8'h10 + 8'(i)}};
    end
    cnt[0] = 22'h0; cnt[1] = 22'h0; lock_mask = 16'h0; cfg_lock = 1'b1; tk_rnd = 1'b0;
    tk_loaded = 1'b1; auth_v = 1'b0; req_valid = 1'b0; ecdh_pair = 1'b0;
    op = 8'h00; p1 = 8'h00; p2 = 16'h0000; len = 7'h00; rdata = 512'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_counter();
    t_refused();
    t_derive_ok();
    t_ecdh();
    tally_and_finish();
  end
  // about twenty commands of under two hundred cycles each fit well inside
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
